// ### logic/fetch_pipeline_params.svh
`ifndef FETCH_PIPELINE_PARAMS_SVH
`define FETCH_PIPELINE_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define REG_PC_LOW_BYTE 4'h0
`define REG_PC_UPPER_BITS 4'h1
`define REG_STATUS 4'h2
`define REG_ACCUMULATOR 4'h3

// ----------------------------------------
// Reset and vector values
// ----------------------------------------
`define RESET_VECTOR 12'h000
`define PC_WIDTH 12
`define PAGE_BITS 8
`define PHASE_COUNT 4

`endif

// ### logic/fetch_pipeline_pkg.sv
package fetch_pipeline_pkg;

	// Four instruction clock phases
	typedef enum logic [1:0] {
		fetch_phase,
		decode_phase,
		execute_phase,
		writeback_phase
	} phase_t;

	// Instruction class presented by the decoder
	typedef enum logic [2:0] {
		op_plain,
		op_jump,
		op_call,
		op_skip,
		op_alu
	} op_class_t;

	// Arithmetic unit operations
	typedef enum logic [3:0] {
		alu_add,
		alu_sub,
		alu_and,
		alu_or,
		alu_xor,
		alu_cpl,
		alu_rr,
		alu_rl,
		alu_inc,
		alu_dec,
		alu_pass
	} alu_op_t;

	// Cycle kind that the sequencer runs
	typedef enum logic {
		cycle_normal,
		cycle_dummy
	} cycle_t;

endpackage

// ### logic/mcu_fetch_pipeline_pc.sv
`timescale 1ns/100ps
`include "fetch_pipeline_params.svh"

// Overview of operation
// - Four non-overlapping phases form one instruction cycle
// - Counter advances and fetches in fetch phase
// - Phases two to four decode and execute
// - Fetch overlaps execute, one instruction per cycle
// - Jump and call take two machine cycles
// - Counter increments except on non-consecutive transfers
// - Jump, call, interrupt, reset load target directly
// - Taken skip discards fetched word, dummy cycle
// - Only low byte readable and writable by software
// - Low byte write jumps within current page
// - Low byte write inserts one dummy cycle
// - Eight-bit arithmetic unit through the accumulator
// - Low byte write keeps upper bits unchanged
// - Execution starts at location zero after reset
module mcu_fetch_pipeline_pc import fetch_pipeline_pkg::*; #(
	parameter int PC_W = `PC_WIDTH,
	parameter int INSTR_W = 15
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic clk_en_i,
	// Program memory
	output logic [PC_W-1:0] fetch_addr_o,
	output logic fetch_strobe_o,
	input wire logic [INSTR_W-1:0] fetch_data_i,
	// Decoded view of the instruction in execution
	input wire logic [2:0] op_class_i,
	input wire logic [3:0] alu_op_i,
	input wire logic [7:0] operand_i,
	input wire logic [PC_W-1:0] target_i,
	input wire logic skip_cond_i,
	// Interrupt vector request
	input wire logic vector_req_i,
	input wire logic [PC_W-1:0] vector_addr_i,
	output logic vector_ack_o,
	// Register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Pipeline status
	output logic [1:0] phase_o,
	output logic [INSTR_W-1:0] exec_instr_o,
	output logic exec_valid_o,
	output logic dummy_cycle_o,
	output logic [7:0] accumulator_o,
	output logic carry_o,
	output logic zero_o
);

	// ----------------------------------------
	// Phase sequencing
	// ----------------------------------------
	phase_t phase;
	cycle_t cycle_kind;
	logic [PC_W-1:0] pc;
	logic [INSTR_W-1:0] fetched_word;
	logic [INSTR_W-1:0] exec_instr;
	logic exec_valid;
	logic [7:0] acc;
	logic carry;
	logic zero;
	logic pcl_write_pending;
	logic [7:0] pcl_wdata;
	logic redirect;
	logic [PC_W-1:0] next_pc;
	logic next_dummy;
	op_class_t op_class;
	alu_op_t alu_op;
	logic [8:0] alu_result;

	assign op_class = op_class_t'(op_class_i);
	assign alu_op = alu_op_t'(alu_op_i);

	// Phase counter wraps after four phases
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase <= fetch_phase;
		end else if (clk_en_i) begin
			phase <= phase_t'(phase + 2'd1);
		end
	end

	// ----------------------------------------
	// Redirect decision at end of writeback
	// ----------------------------------------
	// Decided in last phase so the next fetch phase uses it
	always_comb begin
		redirect = 1'b0;
		next_pc = pc + {{(PC_W-1){1'b0}}, 1'b1};
		next_dummy = 1'b0;
		if (exec_valid && cycle_kind == cycle_normal) begin
			unique case (op_class)
				op_jump, op_call: begin
					redirect = 1'b1;
					next_pc = target_i;
					next_dummy = 1'b1;
				end
				op_skip: begin
					if (skip_cond_i) begin
						next_dummy = 1'b1;
					end else begin
						next_dummy = 1'b0;
					end
				end
				op_plain, op_alu: begin
					next_dummy = 1'b0;
				end
				default: begin
					next_dummy = 1'b0;
				end
			endcase
		end
		if (pcl_write_pending) begin
			redirect = 1'b1;
			next_pc = {pc[PC_W-1:`PAGE_BITS], pcl_wdata};
			next_dummy = 1'b1;
		end
		if (vector_req_i) begin
			redirect = 1'b1;
			next_pc = vector_addr_i;
			next_dummy = 1'b1;
		end
	end

	// ----------------------------------------
	// Program counter
	// ----------------------------------------
	// Counter moves only at the start of the fetch phase
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pc <= PC_W'(`RESET_VECTOR);
		end else if (clk_en_i && phase == writeback_phase) begin
			pc <= next_pc;
		end
	end

	// ----------------------------------------
	// Fetch and execute registers
	// ----------------------------------------
	// Word fetched in the fetch phase waits in a holding register
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fetched_word <= '0;
		end else if (clk_en_i && phase == fetch_phase) begin
			fetched_word <= fetch_data_i;
		end
	end

	// Fetched word executes in the next cycle, or is discarded as a dummy
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			exec_instr <= '0;
			exec_valid <= 1'b0;
			cycle_kind <= cycle_dummy;
		end else if (clk_en_i && phase == writeback_phase) begin
			exec_instr <= fetched_word;
			exec_valid <= !next_dummy;
			cycle_kind <= next_dummy ? cycle_dummy : cycle_normal;
		end
	end

	// Acknowledge a vector when it is taken
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vector_ack_o <= 1'b0;
		end else if (clk_en_i) begin
			vector_ack_o <= vector_req_i && phase == writeback_phase;
		end
	end

	// ----------------------------------------
	// Software access to the low byte
	// ----------------------------------------
	// A write is held until the end of the current cycle
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pcl_write_pending <= 1'b0;
			pcl_wdata <= 8'h00;
		end else if (clk_en_i) begin
			if (reg_wr_i && reg_addr_i == `REG_PC_LOW_BYTE) begin
				pcl_write_pending <= 1'b1;
				pcl_wdata <= reg_wdata_i;
			end else if (phase == writeback_phase) begin
				pcl_write_pending <= 1'b0;
			end
		end
	end

	// Read data one cycle after the strobe
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= 8'h00;
		end else if (clk_en_i) begin
			if (reg_rd_i) begin
				unique case (reg_addr_i)
					`REG_PC_LOW_BYTE: reg_rdata_o <= pc[7:0];
					`REG_STATUS: reg_rdata_o <= {4'h0, cycle_kind == cycle_dummy, zero, carry, exec_valid};
					`REG_ACCUMULATOR: reg_rdata_o <= acc;
					default: reg_rdata_o <= 8'h00;
				endcase
			end else begin
				reg_rdata_o <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// Eight-bit arithmetic unit
	// ----------------------------------------
	always_comb begin
		unique case (alu_op)
			alu_add: alu_result = {1'b0, acc} + {1'b0, operand_i};
			alu_sub: alu_result = {1'b0, acc} - {1'b0, operand_i};
			alu_and: alu_result = {carry, acc & operand_i};
			alu_or: alu_result = {carry, acc | operand_i};
			alu_xor: alu_result = {carry, acc ^ operand_i};
			alu_cpl: alu_result = {carry, ~acc};
			alu_rr: alu_result = {acc[0], carry, acc[7:1]};
			alu_rl: alu_result = {acc[7], acc[6:0], carry};
			alu_inc: alu_result = {carry, acc + 8'h01};
			alu_dec: alu_result = {carry, acc - 8'h01};
			alu_pass: alu_result = {carry, operand_i};
			default: alu_result = {carry, acc};
		endcase
	end

	// Result lands in the accumulator at the end of the execute phase
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			acc <= 8'h00;
			carry <= 1'b0;
			zero <= 1'b0;
		end else if (clk_en_i && phase == execute_phase && exec_valid && op_class == op_alu) begin
			acc <= alu_result[7:0];
			carry <= alu_result[8];
			zero <= alu_result[7:0] == 8'h00;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign fetch_addr_o = pc;
	assign fetch_strobe_o = phase == fetch_phase;
	assign phase_o = phase;
	assign exec_instr_o = exec_instr;
	assign exec_valid_o = exec_valid;
	assign dummy_cycle_o = cycle_kind == cycle_dummy;
	assign accumulator_o = acc;
	assign carry_o = carry;
	assign zero_o = zero;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	phase_order_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase |=> phase == fetch_phase)
		else $error("phase did not wrap to fetch");

	pc_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase != writeback_phase |=> $stable(pc))
		else $error("counter moved outside fetch start");

	pc_incr_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && !redirect |=> pc == $past(pc) + 12'h001)
		else $error("counter did not increment");

	jump_load_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && exec_valid && cycle_kind == cycle_normal
		&& op_class == op_jump && !pcl_write_pending && !vector_req_i |=> pc == $past(target_i))
		else $error("jump target not loaded");

	jump_dummy_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && next_dummy |=> cycle_kind == cycle_dummy)
		else $error("branch lacks second cycle");

	pcl_page_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && pcl_write_pending && !vector_req_i
		|=> pc[11:8] == $past(pc[11:8]) && pc[7:0] == $past(pcl_wdata))
		else $error("low byte jump left page");

	pcl_dummy_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && pcl_write_pending |=> !exec_valid)
		else $error("no dummy after low byte write");

	skip_nodummy_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && exec_valid && cycle_kind == cycle_normal
		&& op_class == op_skip && !skip_cond_i && !pcl_write_pending && !vector_req_i
		|=> cycle_kind == cycle_normal)
		else $error("untaken skip inserted dummy");

	read_low_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && reg_rd_i && reg_addr_i == 4'h1 |=> reg_rdata_o == 8'h00)
		else $error("upper bits became addressable");

	dummy_quiet_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && cycle_kind == cycle_dummy && !pcl_write_pending && !vector_req_i
		|=> pc == $past(pc) + 12'h001)
		else $error("dummy cycle redirected the counter");

	exec_shift_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase |=> exec_instr == $past(fetched_word))
		else $error("fetched word not passed to execute");

	exec_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase != writeback_phase |=> $stable(exec_instr) && $stable(exec_valid))
		else $error("executing word changed mid cycle");

	freeze_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		!clk_en_i |=> $stable(phase) && $stable(pc))
		else $error("state moved while clock enable low");

	vector_take_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && vector_req_i |=> vector_ack_o && pc == $past(vector_addr_i))
		else $error("vector not loaded or acknowledged");

	read_idle_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && !reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outside its cycle");

	alu_add_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == execute_phase && exec_valid && op_class == op_alu && alu_op == alu_add
		|=> {carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(operand_i)})
		else $error("eight bit add result wrong");

	pcl_clear_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && phase == writeback_phase && !(reg_wr_i && reg_addr_i == `REG_PC_LOW_BYTE)
		|=> !pcl_write_pending)
		else $error("low byte write applied twice");

	cover_jump_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
		phase == writeback_phase && op_class == op_jump && exec_valid);
	cover_skip_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
		phase == writeback_phase && op_class == op_skip && skip_cond_i && exec_valid);
	cover_pcl_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
		phase == writeback_phase && pcl_write_pending);
	cover_vector_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
		phase == writeback_phase && vector_req_i && clk_en_i);
	cover_alu_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
		phase == execute_phase && op_class == op_alu && exec_valid && clk_en_i);

endmodule

// ### test/mcu_fetch_pipeline_pc_tb.sv
`timescale 1ns/100ps
`include "fetch_pipeline_params.svh"
module mcu_fetch_pipeline_pc_tb;
	import fetch_pipeline_pkg::*;
	// ----------------------------------------
	// Signals and instance
	// ----------------------------------------
	logic clock_i, arst_n_i, clk_en_i, skip_cond_i, vector_req_i, reg_wr_i, reg_rd_i;
	logic [11:0] fetch_addr_o, target_i, vector_addr_i, exp, pexp;
	logic [14:0] fetch_data_i, exec_instr_o;
	logic [2:0] op_class_i;
	logic [3:0] alu_op_i, reg_addr_i;
	logic [7:0] operand_i, reg_wdata_i, reg_rdata_o, accumulator_o;
	logic [1:0] phase_o, ph;
	logic fetch_strobe_o, vector_ack_o, exec_valid_o, dummy_cycle_o, carry_o, zero_o, dum;
	int error_cnt, total_checks;
	mcu_fetch_pipeline_pc mcu_fetch_pipeline_pc_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.clk_en_i(clk_en_i), .fetch_addr_o(fetch_addr_o), .fetch_strobe_o(fetch_strobe_o),
		.fetch_data_i(fetch_data_i), .op_class_i(op_class_i), .alu_op_i(alu_op_i), .operand_i(operand_i),
		.target_i(target_i), .skip_cond_i(skip_cond_i), .vector_req_i(vector_req_i),
		.vector_addr_i(vector_addr_i), .vector_ack_o(vector_ack_o), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.phase_o(phase_o), .exec_instr_o(exec_instr_o), .exec_valid_o(exec_valid_o),
		.dummy_cycle_o(dummy_cycle_o), .accumulator_o(accumulator_o), .carry_o(carry_o), .zero_o(zero_o));
	// Program memory: word is a marked copy of its address
	assign fetch_data_i = {3'h5, fetch_addr_o};
	// Clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		total_checks++;
		if (got !== want) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic sync0();
		for (int i = 0; i < 8 && phase_o !== 2'h0; i++) @(negedge clock_i);
	endtask
	// Present the executing instruction at the start of phase one
	task automatic start(input op_class_t op, input logic [11:0] tgt, input logic cnd,
			input alu_op_t aop, input logic [7:0] opnd, input logic vreq);
		sync0();
		@(posedge clock_i);
		op_class_i <= op;
		target_i <= tgt;
		skip_cond_i <= cnd;
		alu_op_i <= aop;
		operand_i <= opnd;
		vector_req_i <= vreq;
		@(negedge clock_i);
		chk(phase_o, 2'h1);
		chk(fetch_strobe_o, 1'b0);
		chk(exec_valid_o, !dum);
		chk(dummy_cycle_o, dum);
		if (!dum) chk(exec_instr_o, {3'h5, pexp});
	endtask
	// Wait for the next fetch phase and check the new counter
	task automatic fin(input logic [11:0] e, input logic d);
		sync0();
		chk(fetch_addr_o, e);
		chk(fetch_strobe_o, 1'b1);
		pexp = exp;
		exp = e;
		dum = d;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		@(negedge clock_i);
		chk(reg_rdata_o, e);
		@(negedge clock_i);
		chk(reg_rdata_o, 8'h00);
	endtask
	// Watchdog
	initial begin
		#20000;
		error_cnt++;
		close_out();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{arst_n_i, clk_en_i, skip_cond_i, vector_req_i, reg_wr_i, reg_rd_i} = 6'h00;
		{target_i, operand_i, reg_wdata_i, reg_addr_i} = '0;
		op_class_i = op_plain;
		alu_op_i = alu_pass;
		vector_addr_i = 12'h00c;
		error_cnt = 0;
		total_checks = 0;
		repeat (16) @(posedge clock_i);
		chk(fetch_addr_o, 12'h000);
		arst_n_i <= 1'b1;
		clk_en_i <= 1'b1;
		{exp, pexp, dum} = {24'h0, 1'b1};
		start(op_plain, 0, 0, alu_pass, 0, 0); fin(12'h001, 0);
		start(op_plain, 0, 0, alu_pass, 0, 0); rd(`REG_PC_LOW_BYTE, 8'h01); fin(12'h002, 0);
		start(op_plain, 0, 0, alu_pass, 0, 0); rd(`REG_PC_UPPER_BITS, 8'h00); fin(12'h003, 0);
		start(op_jump, 12'h5a0, 0, alu_pass, 0, 0); fin(12'h5a0, 1);
		start(op_jump, 12'h123, 0, alu_pass, 0, 0); fin(12'h5a1, 0);
		start(op_plain, 0, 0, alu_pass, 0, 0); wr(`REG_PC_LOW_BYTE, 8'hf3); fin(12'h5f3, 1);
		start(op_plain, 0, 0, alu_pass, 0, 0); rd(`REG_PC_LOW_BYTE, 8'hf3); fin(12'h5f4, 0);
		start(op_skip, 0, 1, alu_pass, 0, 0); fin(12'h5f5, 1);
		start(op_plain, 0, 0, alu_pass, 0, 0); fin(12'h5f6, 0);
		start(op_skip, 0, 0, alu_pass, 0, 0); fin(12'h5f7, 0);
		start(op_plain, 0, 0, alu_pass, 0, 0); fin(12'h5f8, 0);
		start(op_jump, 12'h300, 0, alu_pass, 0, 1); fin(12'h00c, 1);
		chk(vector_ack_o, 1'b1);
		start(op_plain, 0, 0, alu_pass, 0, 0); fin(12'h00d, 0);
		start(op_call, 12'h7fe, 0, alu_pass, 0, 0); wr(`REG_PC_LOW_BYTE, 8'h10); fin(12'h010, 1);
		start(op_plain, 0, 0, alu_pass, 0, 0); fin(12'h011, 0);
		start(op_call, 12'h7fe, 0, alu_pass, 0, 0); fin(12'h7fe, 1);
		start(op_plain, 0, 0, alu_pass, 0, 0); fin(12'h7ff, 0);
		start(op_alu, 0, 0, alu_pass, 8'h3c, 0); fin(12'h800, 0);
		chk(accumulator_o, 8'h3c);
		start(op_alu, 0, 0, alu_add, 8'hd0, 0); fin(12'h801, 0);
		chk({carry_o, accumulator_o}, 9'h10c);
		start(op_alu, 0, 0, alu_xor, 8'h0c, 0); fin(12'h802, 0);
		chk({zero_o, accumulator_o}, 9'h100);
		// Frozen clock enable holds phase and counter
		@(posedge clock_i);
		clk_en_i <= 1'b0;
		@(negedge clock_i);
		ph = phase_o;
		repeat (6) @(negedge clock_i);
		chk(phase_o, ph);
		chk(fetch_addr_o, 12'h802);
		// Second reset in mid-run, then a fresh start from location zero
		@(posedge clock_i);
		clk_en_i <= 1'b1;
		arst_n_i <= 1'b0;
		@(negedge clock_i);
		chk(fetch_addr_o, 12'h000);
		chk(phase_o, 2'h0);
		repeat (2) @(posedge clock_i);
		arst_n_i <= 1'b1;
		{exp, pexp, dum} = {24'h0, 1'b1};
		start(op_jump, 12'h400, 0, alu_pass, 0, 0); fin(12'h001, 0);
		start(op_plain, 0, 0, alu_pass, 0, 0); fin(12'h002, 0);
		close_out();
	end
endmodule
